// ### cfl_pkg.sv
// shared constants and types of the configuration pin loader
package cfl_pkg;

    // data and mode widths
    localparam int BYTE_W = 8;
    localparam int MODE_W = 3;
    localparam int SYNC_W = 18;

    // mode_select encodings; any other code is treated as externally clocked serial
    localparam logic [MODE_W-1:0] MODE_SELF_SERIAL = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PARALLEL = 3'h6;
    localparam logic [MODE_W-1:0] MODE_EXT_SERIAL = 3'h7;

    // default sizes
    localparam int LOAD_BYTES_DEF = 16;
    localparam int FIFO_DEPTH_DEF = 16;

    // timing: figures in ns, counts derived from the clock period
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLEAR_TIME_NS = 2000;
    localparam int STARTUP_TIME_NS = 1000;
    localparam int CONFIG_CLOCK_HALF_NS = 400;
    localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONFIG_CLOCK_HALF_CYCLES = (CONFIG_CLOCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : CONFIG_CLOCK_HALF_NS / CLK_PERIOD_NS;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_CLEAR = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_START = 4'b0100,
        ST_USER = 4'b1000
    } cfl_state_e;

endpackage

// ### cfl_stream_if.sv
// valid/ready byte stream between the loader and its buffer
`timescale 1ns/1ps
`default_nettype none
interface cfl_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport source(output data, output valid, input ready);
    modport sink(input data, input valid, output ready);
endinterface
`default_nettype wire

// ### cfl_sync.sv
// two-flop synchroniser for a vector of unrelated pin levels
`timescale 1ns/1ps
`default_nettype none
module cfl_sync #(parameter int W = 1) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### cfl_fifo.sv
// byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cfl_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling and draining sides
    cfl_stream_if.sink wr,
    cfl_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap only works on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("cfl_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = (wp_q == rp_q);
    wire push = wr.valid && !full;
    wire pop = rd.valid && rd.ready;

    // honest flags straight from the pointers
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rp_q[AW-1:0]];

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= wr.data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### cfl_loader.sv
// configuration pin loader: restart, memory clear, parallel and serial load, completion
`timescale 1ns/1ps
`default_nettype none
// Contract
// - config clock input, except driven in self-clocked serial
// - restart pin low starts a new sequence
// - completion pin shows load done, start-up running
// - clear pin held low while memory clears
// - busy paces parallel loading; host obeys it
// - serial modes forward data on chain output
// - parallel mode loads eight data bits per write
// - serial modes load one bit per clock
// - mode comes from three mode select inputs
module cfl_loader #(
    parameter int LOAD_BYTES = cfl_pkg::LOAD_BYTES_DEF,
    parameter int FIFO_DEPTH = cfl_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // restart and straps
    input wire logic RESTART_N,
    input wire logic [cfl_pkg::MODE_W-1:0] MODE_SELECT,
    input wire logic KEEP_PORT,
    // configuration clock pin
    input wire logic CONFIG_CLK_I,
    output logic CONFIG_CLK_O,
    output logic CONFIG_CLK_OE,
    // parallel port, bit 0 doubles as serial data in
    input wire logic [cfl_pkg::BYTE_W-1:0] PARALLEL_CONFIG_DATA,
    input wire logic PORT_SEL_N,
    input wire logic WRITE_N,
    // busy or chain data pin
    output logic BUSY_DOUT_O,
    output logic BUSY_DOUT_OE,
    // completion pin, open drain
    input wire logic LOAD_DONE_I,
    output logic LOAD_DONE_O,
    output logic LOAD_DONE_OE,
    // memory clear pin, open drain, low while clearing
    input wire logic MEM_CLEAR_N_I,
    output logic MEM_CLEAR_N_O,
    output logic MEM_CLEAR_N_OE,
    // loaded bytes toward the fabric
    output logic [cfl_pkg::BYTE_W-1:0] CFG_WORD,
    output logic CFG_VALID,
    input wire logic CFG_READY,
    // status
    output logic USER_MODE,
    output logic PORT_KEPT
);
    import cfl_pkg::*;

    localparam int BCW = $clog2(LOAD_BYTES + 1);
    localparam int CCW = $clog2(CLEAR_CYCLES + STARTUP_CYCLES + 1);
    localparam int DCW = $clog2(CONFIG_CLOCK_HALF_CYCLES + 1);

    if (LOAD_BYTES < 1) begin : g_bad_len
        $error("cfl_loader needs at least one byte to load");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNC_W-1:0] sync_q;
    cfl_sync #(.W(SYNC_W)) u_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .d({RESTART_N, MODE_SELECT, KEEP_PORT, CONFIG_CLK_I, PARALLEL_CONFIG_DATA,
            PORT_SEL_N, WRITE_N, LOAD_DONE_I, MEM_CLEAR_N_I}),
        .q(sync_q)
    );

    // named views of the synchronised pins
    wire restart_n_s = sync_q[17];
    wire [MODE_W-1:0] mode_s = sync_q[16:14];
    wire keep_s = sync_q[13];
    wire config_clock_s = sync_q[12];
    wire [BYTE_W-1:0] pdata_s = sync_q[11:4];
    wire sel_n_s = sync_q[3];
    wire write_n_s = sync_q[2];
    wire done_s = sync_q[1];
    wire clear_n_s = sync_q[0];
    wire din_s = pdata_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // state and registers

    cfl_state_e state_q, state_d;
    logic [MODE_W-1:0] mode_q;
    logic keep_q;
    logic [CCW-1:0] cnt_q;
    logic [BCW-1:0] byte_cnt_q;
    logic [2:0] bit_cnt_q;
    logic [BYTE_W-2:0] shift_q;
    logic config_clock_prev_q;
    logic [DCW-1:0] div_q;
    logic config_clock_o_q;

    cfl_stream_if #(.W(BYTE_W)) fw ();
    cfl_stream_if #(.W(BYTE_W)) fr ();

    cfl_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst_n(RSTN),
        .wr(fw),
        .rd(fr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // mode decode from the latched code, never from live pins
    wire in_load = (state_q == ST_LOAD);
    wire is_par = (mode_q == MODE_PARALLEL);
    wire is_self = (mode_q == MODE_SELF_SERIAL);
    wire is_serial = !is_par;
    wire clear_busy = (state_q == ST_CLEAR) && (cnt_q < CCW'(CLEAR_CYCLES));

    // self-clocked rising edge only when the buffer can take the bit, so it stalls the clock
    wire div_tick = (div_q == DCW'(CONFIG_CLOCK_HALF_CYCLES - 1));
    wire self_rise = in_load && is_self && div_tick && !config_clock_o_q && fw.ready;
    wire ext_rise = config_clock_s && !config_clock_prev_q;
    wire config_clock_rise = is_self ? self_rise : ext_rise;

    // a parallel write needs select and strobe low and room in the buffer
    wire par_take = in_load && is_par && ext_rise && !sel_n_s && !write_n_s && fw.ready;
    wire bit_take = in_load && is_serial && config_clock_rise;
    wire byte_full = bit_take && (bit_cnt_q == 3'h7);
    wire last_byte = fw.valid && fw.ready && (byte_cnt_q == BCW'(LOAD_BYTES - 1));

    // buffer fill side
    assign fw.valid = par_take || byte_full;
    assign fw.data = is_par ? pdata_s : {shift_q, din_s};

    // output stage pulls from the buffer whenever it is empty or being taken
    assign fr.ready = !CFG_VALID || CFG_READY;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    // restart overrides everything and holds the clear phase
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_CLEAR: begin
                if (!clear_busy && clear_n_s) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (last_byte) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                if (cnt_q >= CCW'(STARTUP_CYCLES) && done_s) begin
                    state_d = ST_USER;
                end
            end
            ST_USER: begin
                state_d = ST_USER;
            end
            default: begin
                state_d = ST_CLEAR;
            end
        endcase
        if (!restart_n_s) begin
            state_d = ST_CLEAR;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_CLEAR;
        end else begin
            state_q <= state_d;
        end
    end

    // phase counter restarts on every state change and while restart is held
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q <= '0;
        end else if (state_d != state_q || !restart_n_s) begin
            cnt_q <= '0;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + CCW'(1);
        end
    end

    // mode and port-keep straps follow the pins only in clearing with the phase counter at zero: while restart is held and in the cycle after
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= MODE_EXT_SERIAL;
            keep_q <= 1'b0;
        end else if (state_q == ST_CLEAR && cnt_q == '0) begin
            mode_q <= mode_s;
            keep_q <= keep_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load datapath

    // byte and bit counters, shift register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            byte_cnt_q <= '0;
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else if (!in_load) begin
            byte_cnt_q <= '0;
            bit_cnt_q <= '0;
        end else begin
            if (fw.valid && fw.ready) begin
                byte_cnt_q <= byte_cnt_q + BCW'(1);
            end
            if (bit_take) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shift_q <= {shift_q[BYTE_W-3:0], din_s};
            end
        end
    end

    // edge history and self-clock divider
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            config_clock_prev_q <= 1'b0;
            div_q <= '0;
            config_clock_o_q <= 1'b0;
        end else begin
            config_clock_prev_q <= config_clock_s;
            if (!(in_load && is_self) || div_tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + DCW'(1);
            end
            if (!(in_load && is_self)) begin
                config_clock_o_q <= 1'b0;
            end else if (div_tick && (config_clock_o_q || fw.ready)) begin
                config_clock_o_q <= !config_clock_o_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin outputs, all registered; enables from the next state so they line up with state_q

    wire load_d = (state_d == ST_LOAD);
    wire user_d = (state_d == ST_USER);
    wire port_on_d = (load_d && is_par) || (user_d && keep_q && is_par);
    wire dout_on_d = load_d && is_serial;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CONFIG_CLK_O <= 1'b0;
            CONFIG_CLK_OE <= 1'b0;
            BUSY_DOUT_O <= 1'b0;
            BUSY_DOUT_OE <= 1'b0;
        end else begin
            CONFIG_CLK_O <= config_clock_o_q;
            CONFIG_CLK_OE <= load_d && is_self;
            BUSY_DOUT_OE <= port_on_d || dout_on_d;
            if (is_par) begin
                BUSY_DOUT_O <= !fw.ready || !load_d;
            end else if (bit_take) begin
                BUSY_DOUT_O <= din_s;
            end
        end
    end

    // open-drain pins drive only low; the enable carries the information
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LOAD_DONE_O <= 1'b0;
            LOAD_DONE_OE <= 1'b1;
            MEM_CLEAR_N_O <= 1'b0;
            MEM_CLEAR_N_OE <= 1'b1;
            USER_MODE <= 1'b0;
            PORT_KEPT <= 1'b0;
        end else begin
            LOAD_DONE_O <= 1'b0;
            LOAD_DONE_OE <= (state_d == ST_CLEAR) || load_d;
            MEM_CLEAR_N_O <= 1'b0;
            MEM_CLEAR_N_OE <= (state_d == ST_CLEAR) && (state_q != ST_CLEAR || !restart_n_s || clear_busy);
            USER_MODE <= user_d;
            PORT_KEPT <= user_d && keep_q && is_par;
        end
    end

    // fabric-side output stage
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CFG_WORD <= '0;
            CFG_VALID <= 1'b0;
        end else if (fr.ready) begin
            CFG_WORD <= fr.data;
            CFG_VALID <= fr.valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_config_clock_dir_mode: assert property (@(posedge CLK) disable iff (!RSTN)
        CONFIG_CLK_OE |-> (state_q == ST_LOAD && mode_q == MODE_SELF_SERIAL))
        else $error("config clock driven outside self-clocked load");

    a_restart_clears: assert property (@(posedge CLK) disable iff (!RSTN)
        !restart_n_s |=> state_q == ST_CLEAR && MEM_CLEAR_N_OE && LOAD_DONE_OE)
        else $error("restart did not enter clearing");

    a_done_release: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == ST_LOAD && last_byte && restart_n_s) |=> !LOAD_DONE_OE && state_q == ST_START)
        else $error("completion pin not released after last byte");

    a_clear_holds_low: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(state_q == ST_CLEAR) |-> MEM_CLEAR_N_OE [*8])
        else $error("clear pin released too early");

    a_busy_when_full: assert property (@(posedge CLK) disable iff (!RSTN)
        (in_load && is_par && !fw.ready && restart_n_s) |=> BUSY_DOUT_O && BUSY_DOUT_OE)
        else $error("busy not shown with full buffer");

    a_dout_forwards: assert property (@(posedge CLK) disable iff (!RSTN)
        (bit_take && restart_n_s && !last_byte) |=> BUSY_DOUT_O == $past(din_s) && BUSY_DOUT_OE)
        else $error("chain output did not forward the bit");

    a_par_byte_taken: assert property (@(posedge CLK) disable iff (!RSTN)
        par_take |-> fw.valid && fw.ready && fw.data == pdata_s)
        else $error("parallel byte not written to buffer");

    a_serial_byte: assert property (@(posedge CLK) disable iff (!RSTN)
        byte_full |-> fw.valid && fw.data == {shift_q, din_s} && $past(bit_cnt_q) == 3'h7)
        else $error("serial byte assembled wrongly");

    a_mode_held: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q != ST_CLEAR && $past(state_q) != ST_CLEAR) |-> $stable(mode_q))
        else $error("mode changed during a sequence");

    a_user_release: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == ST_USER && !(keep_q && is_par)) |-> !BUSY_DOUT_OE && !CONFIG_CLK_OE)
        else $error("configuration pins not released in user mode");
endmodule
`default_nettype wire

// ### cfl_host_model.sv
// behavioural configuration host that drives the loader's pins
`timescale 1ns/1ps
`default_nettype none
module cfl_host_model (
    // bench clock
    input wire logic clk,
    // pins from the device
    input wire logic busy,
    input wire logic dev_clk,
    input wire logic dev_clk_oe,
    // pins toward the device
    output logic config_clock,
    output logic [7:0] data,
    output logic sel_n,
    output logic write_n,
    output var int timeouts
);
    // idle pins; config clock starts low, and after ser_bit it stays high until the next bit
    initial begin
        config_clock = 1'b0;
        data = 8'h00;
        sel_n = 1'b1;
        write_n = 1'b1;
        timeouts = 0;
    end

    // one config clock phase of four bench cycles
    task automatic half(input logic lvl);
        @(posedge clk);
        config_clock <= lvl;
        repeat (3) @(posedge clk);
    endtask

    // one byte on the parallel port, select and strobe chosen by the caller
    task automatic par_write(input logic [7:0] b, input logic s_n, input logic w_n);
        int n;
        n = 0;
        @(negedge clk);
        while (busy === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) timeouts++;
        half(1'b0);
        data <= b;
        sel_n <= s_n;
        write_n <= w_n;
        half(1'b1);
        @(posedge clk);
        config_clock <= 1'b0;
        sel_n <= 1'b1;
        write_n <= 1'b1;
        data <= ~b; // released lines must not keep the last byte
    endtask

    // one bit on the serial input with an externally made clock
    task automatic ser_bit(input logic b);
        @(posedge clk);
        config_clock <= 1'b0;
        data <= {~data[7:1], b};
        repeat (3) @(posedge clk);
        half(1'b1);
    endtask

    // one bit under the device's own clock: set right after the previous rise, then wait for the rise that takes it
    task automatic self_bit(input logic b);
        int n;
        n = 0;
        @(posedge clk);
        data[0] <= b;
        while (dev_clk_oe === 1'b1 && dev_clk === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        // the enable drops with the final take, so the rise alone marks it
        while (dev_clk !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) timeouts++;
    endtask
endmodule
`default_nettype wire

// ### cfl_loader_bench.sv
// self-checking bench of the configuration pin loader
`timescale 1ns/1ps
`default_nettype none
module cfl_loader_bench;
    import cfl_pkg::*;
    localparam int NBYTES = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic restart_n = 1'b1;
    logic [MODE_W-1:0] mode_select = MODE_PARALLEL;
    logic keep_port = 1'b1;
    logic cfg_ready = 1'b0;
    logic h_config_clock, h_sel_n, h_write_n, config_clk_i, config_clk_o, config_clk_oe;
    logic busy_dout_o, busy_dout_oe, load_done_i, load_done_o, load_done_oe;
    logic mem_clear_n_i, mem_clear_n_o, mem_clear_n_oe, cfg_valid, user_mode, port_kept;
    logic [7:0] h_data, cfg_word;
    logic [7:0] got[$];
    int fails = 0;
    int checked = 0;
    int host_to;

    // bench clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // wired pin levels: whoever enables drives, otherwise the host's clock or pull-ups
    assign config_clk_i = config_clk_oe ? config_clk_o : h_config_clock;
    assign load_done_i = load_done_oe ? load_done_o : 1'b1;
    assign mem_clear_n_i = mem_clear_n_oe ? mem_clear_n_o : 1'b1;

    cfl_loader #(.LOAD_BYTES(NBYTES), .FIFO_DEPTH(FIFO_DEPTH_DEF)) dut (
        .CLK(clk), .RSTN(rstn), .RESTART_N(restart_n), .MODE_SELECT(mode_select), .KEEP_PORT(keep_port),
        .CONFIG_CLK_I(config_clk_i), .CONFIG_CLK_O(config_clk_o), .CONFIG_CLK_OE(config_clk_oe),
        .PARALLEL_CONFIG_DATA(h_data), .PORT_SEL_N(h_sel_n), .WRITE_N(h_write_n),
        .BUSY_DOUT_O(busy_dout_o), .BUSY_DOUT_OE(busy_dout_oe), .LOAD_DONE_I(load_done_i),
        .LOAD_DONE_O(load_done_o), .LOAD_DONE_OE(load_done_oe), .MEM_CLEAR_N_I(mem_clear_n_i),
        .MEM_CLEAR_N_O(mem_clear_n_o), .MEM_CLEAR_N_OE(mem_clear_n_oe), .CFG_WORD(cfg_word),
        .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready), .USER_MODE(user_mode), .PORT_KEPT(port_kept));

    cfl_host_model host (.clk(clk), .busy(busy_dout_o), .dev_clk(config_clk_o), .dev_clk_oe(config_clk_oe),
        .config_clock(h_config_clock), .data(h_data), .sel_n(h_sel_n), .write_n(h_write_n), .timeouts(host_to));

    // collect every byte the fabric side accepts
    always @(posedge clk) begin
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
            got.push_back(cfg_word);
        end
    end

    function automatic logic [7:0] pat(input int i);
        pat = 8'((i * 37 + 5) % 256);
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // wait for user mode, counting start-up cycles with completion released
    task automatic wait_user();
        int n;
        int s;
        n = 0;
        s = 0;
        while (user_mode !== 1'b1 && n < 3000) begin
            @(negedge clk);
            if (load_done_oe === 1'b0) s++;
            n++;
        end
        check("user mode reached", 8'h01, {7'h0, user_mode});
        check("start-up span", 8'h01, {7'h0, s >= STARTUP_CYCLES - 1});
    endtask

    task automatic finish_load(input logic kept);
        wait_user();
        check("byte count", 8'(NBYTES), 8'(got.size()));
        for (int i = 0; i < NBYTES && i < got.size(); i++) check("loaded byte", pat(i), got[i]);
        check("completion released", 8'h00, {7'h0, load_done_oe});
        check("clear released", 8'h00, {7'h0, mem_clear_n_oe});
        check("port kept", {7'h0, kept}, {7'h0, port_kept});
    endtask

    task automatic restart(input logic [MODE_W-1:0] mode, input logic keep);
        @(posedge clk);
        restart_n <= 1'b0;
        mode_select <= mode;
        keep_port <= keep;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("user mode left", 8'h00, {7'h0, user_mode});
        check("clear driven", 8'h01, {7'h0, mem_clear_n_oe});
        check("completion pulled", 8'h01, {7'h0, load_done_oe});
        @(posedge clk);
        restart_n <= 1'b1;
        got.delete();
    endtask

    task automatic test_reset();
        int n;
        repeat (4) @(posedge clk);
        check("clear in reset", 8'h01, {7'h0, mem_clear_n_oe});
        check("completion in reset", 8'h01, {7'h0, load_done_oe});
        rstn <= 1'b1;
        n = 0;
        while (mem_clear_n_oe !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("clear length", 8'h01, {7'h0, n >= CLEAR_CYCLES && n < 200});
        $display("test_reset done");
    endtask

    task automatic test_parallel();
        int n;
        n = 0;
        while (busy_dout_oe !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("busy driven", 8'h01, {7'h0, busy_dout_oe});
        check("clock pin input", 8'h00, {7'h0, config_clk_oe});
        host.par_write(8'hff, 1'b1, 1'b0);
        host.par_write(8'hfe, 1'b0, 1'b1);
        n = 0;
        while (busy_dout_o !== 1'b1 && n < 18) begin
            host.par_write(pat(n), 1'b0, 1'b0);
            @(negedge clk);
            n++;
        end
        check("bytes before busy", 8'h01, {7'h0, n >= FIFO_DEPTH_DEF && n <= FIFO_DEPTH_DEF + 1});
        @(posedge clk);
        cfg_ready <= 1'b1;
        while (n < NBYTES) begin
            host.par_write(pat(n), 1'b0, 1'b0);
            n++;
        end
        finish_load(1'b1);
        check("busy pin kept", 8'h01, {7'h0, busy_dout_oe});
        $display("test_parallel done");
    endtask

    task automatic test_ext_serial();
        logic [7:0] byte_v;
        int n;
        restart(MODE_EXT_SERIAL, 1'b0);
        // bits sent during the clear phase are dropped, so wait for the chain pin to be driven
        n = 0;
        while (busy_dout_oe !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("chain pin driven", 8'h01, {7'h0, busy_dout_oe});
        @(posedge clk);
        mode_select <= MODE_PARALLEL;
        keep_port <= 1'b1;
        for (int i = 0; i < NBYTES; i++) begin
            byte_v = pat(i);
            for (int b = 7; b >= 0; b--) begin
                host.ser_bit(byte_v[b]);
                @(negedge clk);
                check("chain out bit", {7'h0, byte_v[b]}, {7'h0, busy_dout_o});
            end
        end
        finish_load(1'b0);
        check("chain pin released", 8'h00, {7'h0, busy_dout_oe});
        $display("test_ext_serial done");
    endtask

    task automatic test_self_serial();
        logic [7:0] byte_v;
        restart(MODE_SELF_SERIAL, 1'b0);
        for (int i = 0; i < NBYTES; i++) begin
            byte_v = pat(i);
            for (int b = 7; b >= 0; b--) begin
                host.self_bit(byte_v[b]);
                // the enable drops with the final take, so look after the first bit of each byte
                if (b == 7) check("clock pin driven", 8'h01, {7'h0, config_clk_oe});
            end
        end
        finish_load(1'b0);
        check("clock pin released", 8'h00, {7'h0, config_clk_oe});
        $display("test_self_serial done");
    endtask

    task automatic test_done();
        fails = fails + host_to;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        test_reset();
        test_parallel();
        test_ext_serial();
        test_self_serial();
        test_done();
    end

    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #(CLK_PERIOD_NS * 20000);
        fails++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end
endmodule
`default_nettype wire
